//--- pkg/csp_map.svh
// mode codes, field positions, reset values and timing counts for the security and power control block
`ifndef CSP_MAP_SVH
`define CSP_MAP_SVH

// operating mode bits {boot_mode_pin_high, boot_mode_pin_low}
`define CSP_MODE_SPECIAL_SC 2'h0
`define CSP_MODE_EMUL_NX    2'h1
`define CSP_MODE_SPECIAL_TS 2'h2
`define CSP_MODE_NORMAL_EXP 2'h3
`define CSP_MODE_NORMAL_SC  2'h2

// security byte layout: low two bits, pattern 2'h2 means unsecured
`define CSP_SEC_LSB       0
`define CSP_SEC_MSB       1
`define CSP_SEC_UNSECURED 2'h2
`define CSP_SEC_BYTE_RST  8'hff

// erased flash/eeprom word value
`define CSP_ERASED_WORD 16'hffff

// wake-up settle counts, in clock cycles
`define CSP_FULL_STOP_WAKE_CYC   16'h1000
`define CSP_PSEUDO_STOP_WAKE_CYC 16'h0010

`endif

//--- pkg/csp_pkg.sv
// types for the security and power control block
package csp_pkg;

  typedef enum logic [2:0] {
    CSP_SEC_LOAD,
    CSP_SEC_EVAL,
    CSP_SEC_VERIFY,
    CSP_SEC_READY
  } csp_sec_state_e;

  typedef enum logic [2:0] {
    CSP_PWR_RUN,
    CSP_PWR_WAIT,
    CSP_PWR_STOP,
    CSP_PWR_PSTOP,
    CSP_PWR_WAKE
  } csp_pwr_state_e;

  // debug port request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        mode_wr;
    logic [1:0]  mode;
    logic        jump;
    logic [15:0] addr;
    logic [15:0] wdata;
  } csp_dbg_req_s;

  // cpu bus to internal ram
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } csp_ram_req_s;

  typedef logic [15:0] csp_word_t;

endpackage : csp_pkg

//--- logic/csp_ram.sv
// internal ram, byte banked so misaligned words finish in one cycle
`timescale 1ns/10ps
`default_nettype none

module csp_ram #(
  parameter int AW = 13
) (
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  // access
  input  wire csp_pkg::csp_ram_req_s req_i,
  output logic [15:0]               rdata_o,
  output logic                      ack_o
);

  localparam int DEPTH = 1 << (AW - 1);

  logic [7:0]    bank_even [DEPTH];
  logic [7:0]    bank_odd  [DEPTH];
  logic          odd;
  logic [AW-2:0] row_lo;
  logic [AW-2:0] row_hi;
  logic [AW-2:0] row_e;
  logic [AW-2:0] row_o;
  logic          we_e;
  logic          we_o;
  logic [7:0]    wd_e;
  logic [7:0]    wd_o;

  assign odd    = req_i.addr[0];
  assign row_lo = req_i.addr[AW-1:1];
  assign row_hi = row_lo + {{(AW-2){1'b0}}, 1'b1};
  // misaligned word: even byte comes from next row
  assign row_e  = odd ? row_hi : row_lo;
  assign row_o  = row_lo;
  assign we_e   = req_i.valid & req_i.write & (req_i.word | ~odd);
  assign we_o   = req_i.valid & req_i.write & (req_i.word | odd);
  assign wd_e   = odd ? req_i.wdata[7:0] : req_i.wdata[15:8];
  assign wd_o   = (odd | ~req_i.word) ? req_i.wdata[15:8] : req_i.wdata[7:0];

  always_ff @(posedge clock_i)
  begin
    if (we_e)
      bank_even[row_e] <= wd_e;
    if (we_o)
      bank_odd[row_o] <= (odd | req_i.word) ? wd_o : req_i.wdata[7:0];
  end

  // single cycle, no wait states
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= 16'h0000;
      ack_o   <= 1'b0;
    end
    else
    begin
      ack_o <= req_i.valid;
      if (req_i.valid & ~req_i.write)
        rdata_o <= odd ? {bank_odd[row_o], bank_even[row_e]}
                       : {bank_even[row_e], bank_odd[row_o]};
    end
  end

endmodule : csp_ram

`default_nettype wire

//--- logic/csp_wake_timer.sv
// wake-up settle counter after stop or pseudo-stop
`timescale 1ns/10ps
`default_nettype none

module csp_wake_timer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  // control
  input  wire logic         start_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);

  logic [W-1:0] cnt;
  logic         run;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= '0;
      run <= 1'b0;
    end
    else if (start_i)
    begin
      cnt <= count_i;
      run <= 1'b1;
    end
    else if (run)
    begin
      cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      if (cnt <= {{(W-1){1'b0}}, 1'b1})
        run <= 1'b0;
    end
  end

  assign done_o = run & (cnt <= {{(W-1){1'b0}}, 1'b1});

endmodule : csp_wake_timer

`default_nettype wire

//--- logic/csp_ctrl.sv
// security and low-power mode control with internal ram
`timescale 1ns/10ps
`default_nettype none
`include "csp_map.svh"

module csp_ctrl #(
  parameter int                 NVM_AW       = 16,
  parameter int                 RAM_AW       = 13,
  parameter logic [NVM_AW-1:0]  SEC_ADDR     = 16'hff0f,
  parameter logic [NVM_AW-1:0]  NVM_LAST     = 16'hffff,
  parameter logic [15:0]        FULL_WAKE    = `CSP_FULL_STOP_WAKE_CYC,
  parameter logic [15:0]        PSEUDO_WAKE  = `CSP_PSEUDO_STOP_WAKE_CYC
) (
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  // mode select pins
  input  wire logic                  boot_mode_pin_low_i,
  input  wire logic                  boot_mode_pin_high_i,
  // non-volatile array read port
  output logic                       nvm_rd_o,
  output logic [NVM_AW-1:0]          nvm_addr_o,
  input  wire logic [15:0]           nvm_rdata_i,
  input  wire logic                  nvm_rvalid_i,
  // security bit programming
  input  wire logic                  sec_prog_req_i,
  input  wire logic [7:0]            sec_prog_data_i,
  output logic                       sec_prog_en_o,
  output logic                       sec_prog_o,
  output logic [7:0]                 sec_prog_data_o,
  // debug port
  input  wire csp_pkg::csp_dbg_req_s dbg_req_i,
  output logic                       dbg_ack_o,
  output logic                       dbg_reject_o,
  output logic                       dbg_pass_o,
  output logic                       jump_o,
  output logic [15:0]                jump_addr_o,
  // cpu events
  input  wire logic                  stop_instr_i,
  input  wire logic                  idle_instr_i,
  input  wire logic                  pseudo_stop_sel_i,
  input  wire logic                  maskable_irq_pin_i,
  input  wire logic                  nonmaskable_interrupt_pin_i,
  input  wire logic [15:0]           cpu_addr_i,
  input  wire logic [15:0]           cpu_wdata_i,
  // cpu ram access
  input  wire csp_pkg::csp_ram_req_s ram_req_i,
  output logic [15:0]                ram_rdata_o,
  output logic                       ram_ack_o,
  // status and gating
  output logic [1:0]                 mode_o,
  output logic                       secured_o,
  output logic                       sec_ready_o,
  output logic                       erase_ok_o,
  output logic                       nvm_enable_o,
  output logic                       ext_exec_en_o,
  output logic                       cpu_run_o,
  output logic [15:0]                cpu_addr_o,
  output logic [15:0]                cpu_wdata_o,
  output logic                       osc_en_o,
  output logic                       clocks_en_o,
  output logic                       tick_wdog_en_o,
  output logic                       periph_en_o,
  output logic                       periph_gate_allow_o
);

  csp_pkg::csp_sec_state_e sec_state;
  csp_pkg::csp_pwr_state_e pwr_state;
  logic              mode_cap;
  logic              secured;
  logic              erase_ok;
  logic [NVM_AW-1:0] scan_addr;
  logic              wake_start;
  logic              wake_done;
  logic [15:0]       wake_cnt;
  logic              irq_any;
  logic              special_sc;
  logic              expanded;
  logic              mode_write_ok;

  assign special_sc = (mode_o == `CSP_MODE_SPECIAL_SC);
  assign expanded   = mode_o[0];
  assign irq_any    = maskable_irq_pin_i | ~nonmaskable_interrupt_pin_i;

  // mode pins sampled once after reset release
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_o   <= `CSP_MODE_NORMAL_SC;
      mode_cap <= 1'b0;
    end
    else if (!mode_cap)
    begin
      mode_o   <= {boot_mode_pin_high_i, boot_mode_pin_low_i};
      mode_cap <= 1'b1;
    end
    else if (mode_write_ok)
      mode_o <= dbg_req_i.mode;
  end

  // security sequencing: load byte, then erase verify in special single-chip mode only
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sec_state <= csp_pkg::CSP_SEC_LOAD;
      secured   <= 1'b1;
      erase_ok  <= 1'b0;
      scan_addr <= '0;
    end
    else
    begin
      unique case (sec_state)
        csp_pkg::CSP_SEC_LOAD:
          if (mode_cap && nvm_rvalid_i)
          begin
            // byte taken in the cycle its valid stands
            secured   <= nvm_rdata_i[`CSP_SEC_MSB:`CSP_SEC_LSB] != `CSP_SEC_UNSECURED;
            sec_state <= csp_pkg::CSP_SEC_EVAL;
          end
        csp_pkg::CSP_SEC_EVAL:
        begin
          scan_addr <= '0;
          sec_state <= special_sc ? csp_pkg::CSP_SEC_VERIFY : csp_pkg::CSP_SEC_READY;
        end
        csp_pkg::CSP_SEC_VERIFY:
          if (nvm_rvalid_i)
          begin
            if (nvm_rdata_i != `CSP_ERASED_WORD)
              sec_state <= csp_pkg::CSP_SEC_READY;
            else if (scan_addr == NVM_LAST)
            begin
              erase_ok  <= 1'b1;
              sec_state <= csp_pkg::CSP_SEC_READY;
            end
            else
              scan_addr <= scan_addr + {{(NVM_AW-1){1'b0}}, 1'b1};
          end
        csp_pkg::CSP_SEC_READY:
          if (sec_prog_en_o && sec_prog_req_i &&
              sec_prog_data_i[`CSP_SEC_MSB:`CSP_SEC_LSB] == `CSP_SEC_UNSECURED)
            secured <= 1'b0;
        default:
          sec_state <= csp_pkg::CSP_SEC_LOAD;
      endcase
    end
  end

  // nvm reads, enabled gating and security programming
  assign nvm_rd_o     = (sec_state == csp_pkg::CSP_SEC_LOAD && mode_cap) ||
                        (sec_state == csp_pkg::CSP_SEC_VERIFY);
  assign nvm_addr_o   = (sec_state == csp_pkg::CSP_SEC_VERIFY) ? scan_addr : SEC_ADDR;
  assign sec_ready_o  = (sec_state == csp_pkg::CSP_SEC_READY);
  assign secured_o    = secured;
  assign erase_ok_o   = erase_ok;
  assign sec_prog_en_o   = sec_ready_o & (~secured | erase_ok);
  assign sec_prog_o      = sec_prog_en_o & sec_prog_req_i;
  assign sec_prog_data_o = sec_prog_data_i;
  // secured expanded: flash and eeprom off, external run allowed
  assign nvm_enable_o  = sec_ready_o & ~(secured & expanded);
  assign ext_exec_en_o = sec_ready_o & expanded;

  // debug port: any access rejected while secured
  assign dbg_pass_o    = dbg_req_i.valid & sec_ready_o & ~secured;
  assign dbg_ack_o     = dbg_pass_o;
  assign dbg_reject_o  = dbg_req_i.valid & ~dbg_pass_o;
  assign mode_write_ok = dbg_pass_o & dbg_req_i.mode_wr & special_sc;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      jump_o      <= 1'b0;
      jump_addr_o <= 16'h0000;
    end
    else
    begin
      jump_o <= dbg_pass_o & dbg_req_i.jump;
      if (dbg_pass_o & dbg_req_i.jump)
        jump_addr_o <= dbg_req_i.addr;
    end
  end

  // power mode sequencing
  assign wake_start = irq_any && (pwr_state == csp_pkg::CSP_PWR_STOP ||
                                  pwr_state == csp_pkg::CSP_PWR_PSTOP);
  assign wake_cnt   = (pwr_state == csp_pkg::CSP_PWR_PSTOP) ? PSEUDO_WAKE : FULL_WAKE;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pwr_state <= csp_pkg::CSP_PWR_RUN;
    else
    begin
      unique case (pwr_state)
        csp_pkg::CSP_PWR_RUN:
          if (stop_instr_i)
            pwr_state <= pseudo_stop_sel_i ? csp_pkg::CSP_PWR_PSTOP : csp_pkg::CSP_PWR_STOP;
          else if (idle_instr_i)
            pwr_state <= csp_pkg::CSP_PWR_WAIT;
        csp_pkg::CSP_PWR_WAIT:
          if (irq_any)
            pwr_state <= csp_pkg::CSP_PWR_RUN;
        csp_pkg::CSP_PWR_STOP,
        csp_pkg::CSP_PWR_PSTOP:
          if (irq_any)
            pwr_state <= csp_pkg::CSP_PWR_WAKE;
        csp_pkg::CSP_PWR_WAKE:
          if (wake_done)
            pwr_state <= csp_pkg::CSP_PWR_RUN;
        default:
          pwr_state <= csp_pkg::CSP_PWR_RUN;
      endcase
    end
  end

  csp_wake_timer #(
    .W (16)
  ) u_wake (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .start_i (wake_start),
    .count_i (wake_cnt),
    .done_o  (wake_done)
  );

  assign cpu_run_o      = (pwr_state == csp_pkg::CSP_PWR_RUN);
  assign osc_en_o       = (pwr_state != csp_pkg::CSP_PWR_STOP);
  assign clocks_en_o    = (pwr_state == csp_pkg::CSP_PWR_RUN) ||
                          (pwr_state == csp_pkg::CSP_PWR_WAIT);
  assign tick_wdog_en_o = (pwr_state != csp_pkg::CSP_PWR_STOP);
  assign periph_en_o    = clocks_en_o;
  assign periph_gate_allow_o = (pwr_state == csp_pkg::CSP_PWR_WAIT);

  // cpu buses frozen outside run
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cpu_addr_o  <= 16'h0000;
      cpu_wdata_o <= 16'h0000;
    end
    else if (cpu_run_o)
    begin
      cpu_addr_o  <= cpu_addr_i;
      cpu_wdata_o <= cpu_wdata_i;
    end
  end

  csp_ram #(
    .AW (RAM_AW)
  ) u_ram (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .req_i   (ram_req_i),
    .rdata_o (ram_rdata_o),
    .ack_o   (ram_ack_o)
  );

endmodule : csp_ctrl

`default_nettype wire

//--- dv/csp_ctrl_assertions.sv
// port assertions for the security and power control block
`timescale 1ns/10ps
`default_nettype none

module csp_ctrl_assertions (
  // clock and reset
  input wire logic                  clock_i,
  input wire logic                  rst_n_i,
  // watched inputs
  input wire csp_pkg::csp_dbg_req_s dbg_req_i,
  input wire csp_pkg::csp_ram_req_s ram_req_i,
  input wire logic                  stop_instr_i,
  input wire logic                  idle_instr_i,
  input wire logic                  pseudo_stop_sel_i,
  input wire logic                  maskable_irq_pin_i,
  input wire logic                  nonmaskable_interrupt_pin_i,
  // watched outputs
  input wire logic                  dbg_ack_o,
  input wire logic                  dbg_reject_o,
  input wire logic                  jump_o,
  input wire logic [15:0]           jump_addr_o,
  input wire logic                  secured_o,
  input wire logic                  sec_ready_o,
  input wire logic                  erase_ok_o,
  input wire logic                  sec_prog_en_o,
  input wire logic                  sec_prog_o,
  input wire logic [1:0]            mode_o,
  input wire logic                  nvm_enable_o,
  input wire logic                  cpu_run_o,
  input wire logic [15:0]           cpu_addr_o,
  input wire logic                  osc_en_o,
  input wire logic                  clocks_en_o,
  input wire logic                  tick_wdog_en_o,
  input wire logic                  periph_en_o,
  input wire logic                  ram_ack_o
);
  wire irq_seen = maskable_irq_pin_i | ~nonmaskable_interrupt_pin_i;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  a_dbg_sec_reject: assert property (dbg_req_i.valid && secured_o |-> dbg_reject_o && !dbg_ack_o)
    else $error("debug request served while secured");
  a_jump_redirect: assert property (dbg_req_i.valid && dbg_req_i.jump && dbg_ack_o
    |=> jump_o && jump_addr_o == $past(dbg_req_i.addr)) else $error("jump not issued");
  a_exp_mem_off: assert property (sec_ready_o && secured_o && mode_o[0] |-> !nvm_enable_o)
    else $error("internal memories on in secured expanded mode");
  a_prog_gate: assert property (sec_prog_o |-> sec_prog_en_o && (!secured_o || erase_ok_o))
    else $error("security bits programmed without erase check");
  a_full_stop: assert property (cpu_run_o && stop_instr_i && !pseudo_stop_sel_i
    |=> !osc_en_o && !clocks_en_o && !cpu_run_o) else $error("full stop left clocks running");
  a_pstop_keep: assert property (cpu_run_o && stop_instr_i && pseudo_stop_sel_i
    |=> osc_en_o && tick_wdog_en_o && !periph_en_o) else $error("pseudo stop state wrong");
  a_stop_hold: assert property (!osc_en_o && !irq_seen |=> !osc_en_o)
    else $error("full stop left without cause");
  a_idle_wait: assert property (cpu_run_o && idle_instr_i && !stop_instr_i
    |=> !cpu_run_o && periph_en_o) else $error("wait entry wrong");
  a_wait_static: assert property (!cpu_run_o ##1 !cpu_run_o |-> $stable(cpu_addr_o))
    else $error("cpu bus moved while halted");
  a_wait_wake: assert property (!cpu_run_o && clocks_en_o && irq_seen |=> cpu_run_o)
    else $error("no wake from wait");
  a_gate_unready: assert property (!sec_ready_o |-> !nvm_enable_o && !dbg_ack_o)
    else $error("access enabled before security evaluated");
  a_ram_single: assert property (ram_req_i.valid |=> ram_ack_o)
    else $error("ram access took more than one cycle");

  c_reject: cover property (secured_o && dbg_reject_o);
  c_jump: cover property (jump_o);
  c_stop: cover property (!osc_en_o);
  c_ram: cover property (ram_ack_o);
endmodule : csp_ctrl_assertions

bind csp_ctrl csp_ctrl_assertions csp_ctrl_assertions_i (.clock_i, .rst_n_i, .dbg_req_i, .ram_req_i, .stop_instr_i,
  .idle_instr_i, .pseudo_stop_sel_i, .maskable_irq_pin_i, .nonmaskable_interrupt_pin_i, .dbg_ack_o, .dbg_reject_o,
  .jump_o, .jump_addr_o, .secured_o, .sec_ready_o, .erase_ok_o, .sec_prog_en_o, .sec_prog_o, .mode_o,
  .nvm_enable_o, .cpu_run_o, .cpu_addr_o, .osc_en_o, .clocks_en_o, .tick_wdog_en_o, .periph_en_o, .ram_ack_o);

`default_nettype wire

//--- dv/csp_nvm_model.sv
// flash array model answering security byte and erase check reads
`timescale 1ns/10ps
`default_nettype none

module csp_nvm_model #(
  parameter logic [15:0] SEC_ADDR = 16'hff0f
) (
  // clock
  input wire logic         clock_i,
  // read port
  input wire logic         nvm_rd_i,
  input wire logic [15:0]  nvm_addr_i,
  output logic [15:0]      nvm_rdata_o,
  output logic             nvm_rvalid_o,
  // array contents and pacing
  input wire logic [7:0]   sec_byte_i,
  input wire logic         erased_i,
  input wire logic         slow_i
);
  logic [1:0] gap;

  initial
  begin
    nvm_rvalid_o = 1'b0;
    nvm_rdata_o = 16'h0000;
    gap = 2'h0;
  end

  always @(posedge clock_i)
  begin
    if (nvm_rd_i && !nvm_rvalid_o && gap == {1'b0, slow_i})
    begin
      nvm_rvalid_o <= #1 1'b1;
      // security byte inside the array, rest erased or not
      nvm_rdata_o <= #1 (nvm_addr_i == SEC_ADDR) ? {8'hff, sec_byte_i} : (erased_i ? 16'hffff : 16'h00a5);
      gap <= #1 2'h0;
    end
    else
    begin
      nvm_rvalid_o <= #1 1'b0;
      // data inverted every cycle outside an answer
      nvm_rdata_o <= #1 ~nvm_rdata_o;
      gap <= #1 (nvm_rd_i && !nvm_rvalid_o) ? gap + 2'h1 : 2'h0;
    end
  end
endmodule : csp_nvm_model

`default_nettype wire

//--- dv/chip_security_and_power_modes_bench.sv
// self-checking bench for the security and power control block
`timescale 1ns/10ps
`default_nettype none

module chip_security_and_power_modes_bench;
  logic clock_i, rst_n_i, boot_mode_pin_low_i, boot_mode_pin_high_i, nvm_rvalid_i, sec_prog_req_i;
  logic stop_instr_i, idle_instr_i, pseudo_stop_sel_i, maskable_irq_pin_i, nonmaskable_interrupt_pin_i;
  logic [15:0] nvm_rdata_i, cpu_addr_i, cpu_wdata_i, nvm_addr_o, jump_addr_o, ram_rdata_o, cpu_addr_o, cpu_wdata_o;
  logic [7:0] sec_prog_data_i, sec_prog_data_o, sec_byte;
  logic [1:0] mode_o;
  logic erased, slow, nvm_rd_o, sec_prog_en_o, sec_prog_o, dbg_ack_o, dbg_reject_o, dbg_pass_o, jump_o, ram_ack_o;
  logic secured_o, sec_ready_o, erase_ok_o, nvm_enable_o, ext_exec_en_o, cpu_run_o, osc_en_o, clocks_en_o;
  logic tick_wdog_en_o, periph_en_o, periph_gate_allow_o;
  csp_pkg::csp_dbg_req_s dbg_req_i;
  csp_pkg::csp_ram_req_s ram_req_i;
  int n_errors = 0;
  int compares = 0;

  csp_ctrl #(.NVM_LAST(16'h0003), .FULL_WAKE(16'h0004)) csp_ctrl_i (.clock_i, .rst_n_i, .boot_mode_pin_low_i,
    .boot_mode_pin_high_i, .nvm_rd_o, .nvm_addr_o, .nvm_rdata_i, .nvm_rvalid_i, .sec_prog_req_i, .sec_prog_data_i,
    .sec_prog_en_o, .sec_prog_o, .sec_prog_data_o, .dbg_req_i, .dbg_ack_o, .dbg_reject_o, .dbg_pass_o, .jump_o,
    .jump_addr_o, .stop_instr_i, .idle_instr_i, .pseudo_stop_sel_i, .maskable_irq_pin_i,
    .nonmaskable_interrupt_pin_i, .cpu_addr_i, .cpu_wdata_i, .ram_req_i, .ram_rdata_o, .ram_ack_o, .mode_o,
    .secured_o, .sec_ready_o, .erase_ok_o, .nvm_enable_o, .ext_exec_en_o, .cpu_run_o, .cpu_addr_o, .cpu_wdata_o,
    .osc_en_o, .clocks_en_o, .tick_wdog_en_o, .periph_en_o, .periph_gate_allow_o);

  csp_nvm_model csp_nvm_model_i (.clock_i, .nvm_rd_i(nvm_rd_o), .nvm_addr_i(nvm_addr_o), .nvm_rdata_o(nvm_rdata_i),
    .nvm_rvalid_o(nvm_rvalid_i), .sec_byte_i(sec_byte), .erased_i(erased), .slow_i(slow));

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : step

  task automatic wait_hi(input logic sel, output int n);
    for (n = 0; n < 300 && (sel ? cpu_run_o : sec_ready_o) !== 1'b1; n++)
      step(1);
    if (n == 300)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      results;
    end
  endtask : wait_hi

  task automatic do_reset(input logic [1:0] m, input logic [7:0] sb, input logic er);
    int n;
    rst_n_i = 1'b0;
    {boot_mode_pin_high_i, boot_mode_pin_low_i} = m;
    sec_byte = sb;
    erased = er;
    step(12);
    rst_n_i = 1'b1;
    step(2);
    {boot_mode_pin_high_i, boot_mode_pin_low_i} = ~m;
    wait_hi(1'b0, n);
    check(16'(mode_o), 16'(m));
  endtask : do_reset

  task automatic t_secured;
    do_reset(2'h2, 8'hff, 1'b0);
    check(16'(secured_o), 16'h1);
    check(16'(nvm_enable_o), 16'h1);
    dbg_req_i = '{valid: 1'b1, default: '0};
    #1 check(16'({dbg_reject_o, dbg_ack_o}), 16'h2);
    dbg_req_i = '0;
    do_reset(2'h3, 8'hff, 1'b0);
    check(16'(nvm_enable_o), 16'h0);
    check(16'(ext_exec_en_o), 16'h1);
    dbg_req_i = '{valid: 1'b1, write: 1'b1, default: '0};
    #1 check(16'({dbg_reject_o, dbg_ack_o}), 16'h2);
    dbg_req_i = '0;
    do_reset(2'h2, 8'hfe, 1'b0);
    check(16'(secured_o), 16'h0);
    dbg_req_i = '{valid: 1'b1, default: '0};
    #1 check(16'({dbg_reject_o, dbg_ack_o, dbg_pass_o}), 16'h3);
    dbg_req_i = '0;
    $display("secured modes done");
  endtask : t_secured

  task automatic t_unsecure;
    do_reset(2'h0, 8'hff, 1'b1);
    check(16'({secured_o, erase_ok_o, sec_prog_en_o}), 16'h7);
    sec_prog_req_i = 1'b1;
    sec_prog_data_i = 8'hfe;
    #1 check(16'({sec_prog_o, sec_prog_data_o}), 16'h1fe);
    step(1);
    sec_prog_req_i = 1'b0;
    check(16'(secured_o), 16'h0);
    dbg_req_i = '{valid: 1'b1, mode_wr: 1'b1, mode: 2'h3, default: '0};
    #1 check(16'(dbg_ack_o), 16'h1);
    step(1);
    dbg_req_i = '{valid: 1'b1, jump: 1'b1, addr: 16'h8000, default: '0};
    check(16'(mode_o), 16'h3);
    step(1);
    dbg_req_i = '0;
    check(16'(jump_o), 16'h1);
    check(jump_addr_o, 16'h8000);
    do_reset(2'h0, 8'hff, 1'b1);
    check(16'(secured_o), 16'h1);
    $display("unsecure sequence done");
  endtask : t_unsecure

  task automatic t_not_erased;
    slow = 1'b1;
    do_reset(2'h0, 8'hff, 1'b0);
    check(16'({erase_ok_o, sec_prog_en_o}), 16'h0);
    sec_prog_req_i = 1'b1;
    sec_prog_data_i = 8'hfe;
    #1 check(16'(sec_prog_o), 16'h0);
    step(1);
    sec_prog_req_i = 1'b0;
    check(16'(secured_o), 16'h1);
    slow = 1'b0;
    $display("erase check failure done");
  endtask : t_not_erased

  task automatic t_power;
    int n;
    stop_instr_i = 1'b1;
    step(1);
    stop_instr_i = 1'b0;
    check(16'({osc_en_o, clocks_en_o, cpu_run_o}), 16'h0);
    step(6);
    check(16'(osc_en_o), 16'h0);
    nonmaskable_interrupt_pin_i = 1'b0;
    wait_hi(1'b1, n);
    nonmaskable_interrupt_pin_i = 1'b1;
    check(16'(n), 16'h5);
    pseudo_stop_sel_i = 1'b1;
    stop_instr_i = 1'b1;
    step(1);
    stop_instr_i = 1'b0;
    check(16'({osc_en_o, tick_wdog_en_o, periph_en_o, cpu_run_o}), 16'hc);
    maskable_irq_pin_i = 1'b1;
    wait_hi(1'b1, n);
    maskable_irq_pin_i = 1'b0;
    check(16'(n), 16'h11);
    idle_instr_i = 1'b1;
    step(1);
    idle_instr_i = 1'b0;
    check(16'({cpu_run_o, periph_en_o, periph_gate_allow_o}), 16'h3);
    cpu_addr_i = 16'h1357;
    cpu_wdata_i = 16'h2468;
    step(3);
    check(cpu_addr_o, 16'h0101);
    check(cpu_wdata_o, 16'h0202);
    maskable_irq_pin_i = 1'b1;
    step(1);
    maskable_irq_pin_i = 1'b0;
    check(16'(cpu_run_o), 16'h1);
    step(1);
    check(cpu_addr_o, 16'h1357);
    check(cpu_wdata_o, 16'h2468);
    $display("power modes done");
  endtask : t_power

  task automatic t_ram;
    ram_req_i = '{valid: 1'b1, write: 1'b1, word: 1'b1, addr: 16'h0005, wdata: 16'hbeef};
    step(1);
    check(16'(ram_ack_o), 16'h1);
    ram_req_i = '{valid: 1'b1, word: 1'b1, addr: 16'h0005, default: '0};
    step(1);
    ram_req_i = '0;
    check(16'(ram_ack_o), 16'h1);
    check(ram_rdata_o, 16'hbeef);
    step(1);
    check(16'(ram_ack_o), 16'h0);
    $display("misaligned ram done");
  endtask : t_ram

  initial
  begin
    {rst_n_i, boot_mode_pin_low_i, boot_mode_pin_high_i, sec_prog_req_i, stop_instr_i, idle_instr_i} = '0;
    {pseudo_stop_sel_i, maskable_irq_pin_i, erased, slow} = '0;
    nonmaskable_interrupt_pin_i = 1'b1;
    sec_prog_data_i = 8'h00;
    sec_byte = 8'hff;
    cpu_addr_i = 16'h0101;
    cpu_wdata_i = 16'h0202;
    dbg_req_i = '0;
    ram_req_i = '0;
    t_secured;
    t_unsecure;
    t_not_erased;
    t_power;
    t_ram;
    results;
  end
endmodule : chip_security_and_power_modes_bench

`default_nettype wire
